// >>> design/ssp_port.sv
// synchronous serial port, master or slave, 8/16-bit full duplex shifter
// assumes control bits are held by software outside, pins are synchronous
// to clk, and the pad logic resolves each pin from its out/oe pair
//
// Operation
// RL1: 8 or 16 bits, MSB or LSB first
// RL2: master clock from 254-value divisor
// RL3: shift out and sample in together
// RL4: unselected slave never drives its output
// RL5: data write during transfer flags collision
// RL6: mode fault turns off output drivers
// RL7: configuration accepted any time
// RL8: status bits set only by hardware
// RL9: master data write starts transfer
// RL10: transfer-complete flag set in both modes
// RL11: read buffer; uncleared flag means overrun, discard
// RL12: data write loads shifter directly
// RL13: open-drain select on all output pins
// RL14: pin roles swap between master and slave
// RL15: master ignores externally begun transfers
// RL16: select active while master means mode fault
// RL17: interrupt request follows flag when enabled
// RL18: status read then data access clears flag
// RL19: phase and polarity pick drive/sample edges
// RL20: enabled slave starts on select low
// RL21: divisor ignored in slave mode
// RL22: only one master on the bus
// RL23: phase zero samples odd edges, shifts even
// RL24: phase one shifts odd edges, samples even
// RL25: divisor zero or one stops serial clock
// RL26: collision keeps transfer, drops data, no interrupt
// RL27: master idles clock at polarity level
`timescale 1ns/100ps
`default_nettype none

module ssp_port
   import ssp_pkg::*;
(
   input  wire logic                        clk,
   input  wire logic                        rst,
   // configuration
   input  wire logic                        portEnable,
   input  wire logic                        masterSelect,
   input  wire logic                        clockPhaseSel,
   input  wire logic                        clockPolaritySel,
   input  wire logic                        lowBitFirst,
   input  wire logic                        wordSize16,
   input  wire logic                        openDrainSelect,
   input  wire logic                        xferIrqEnable,
   input  wire logic [ssp_pkg::DIV_W-1:0]   bitRateDivisor,
   // software access strobes
   input  wire logic                        statusRd,
   input  wire logic                        dataRd,
   input  wire logic                        dataWr,
   input  wire logic [ssp_pkg::SHIFT_W-1:0] wrData,
   output logic      [ssp_pkg::SHIFT_W-1:0] rdData_q,
   output logic                             xferDoneFlag_q,
   output logic                             writeCollisionFlag_q,
   output logic                             overrunFlag_q,
   output logic                             modeFaultFlag_q,
   output logic                             irqReq_q,
   // serial pins
   input  wire logic                        sckIn,
   output logic                             sckOut_q,
   output logic                             sckOe_q,
   input  wire logic                        mosiIn,
   output logic                             mosiOut_q,
   output logic                             mosiOe_q,
   input  wire logic                        misoIn,
   output logic                             misoOut_q,
   output logic                             misoOe_q,
   input  wire logic                        ssN
);
   import ssp_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [SHIFT_W-1:0] shift_q;
   logic [SHIFT_W-1:0] shift_d;
   logic [DIV_W-1:0]   divCnt_q;
   logic [EDGE_W-1:0]  edgeCnt_q;
   logic               mstBusy_q;
   logic               slvBusy_q;
   logic               sckLevel_q;
   logic               sckPrev_q;
   logic               outBit_q;
   logic               statusSeen_q;

   // ---------------------------------------------------------------
   // decode
   // ---------------------------------------------------------------
   logic              isMaster;
   logic              slaveSel;
   logic              faultNow;
   logic [EDGE_W-1:0] edgesTotal;
   logic [EDGE_W-1:0] lastSample;
   logic              mstTick;
   logic              mstEdge;
   logic              mstEnd;
   logic              slvEdge;
   logic              anyEdge;
   logic              sampleEdge;
   logic              driveEdge;
   logic              slvDone;
   logic              xferEvt;
   logic              busyAny;
   logic              loadOk;
   logic              collide;
   logic              clrSeq;
   logic              inBit;
   logic              doneKeep;

   function automatic logic firstBit(input logic [SHIFT_W-1:0] w, input logic lsb, input logic wide);
      firstBit = lsb ? w[0] : (wide ? w[SHIFT_W-1] : w[BYTE_W-1]);
   endfunction

   // RL7: config read live
   always_comb begin
      // RL14: master role only while no fault
      isMaster   = portEnable & masterSelect & ~modeFaultFlag_q;
      // RL20: slave selected by low select
      slaveSel   = portEnable & ~masterSelect & ~ssN;
      // RL16: select asserted while master
      faultNow   = portEnable & masterSelect & ~ssN;
      // RL1: size picks edge count
      edgesTotal = wordSize16 ? EDGES_WORD : EDGES_BYTE;
      lastSample = edgesTotal - EDGE_LAST_OFS + {{(EDGE_W-1){1'b0}}, clockPhaseSel};
      // RL25: low divisors never tick
      mstTick    = mstBusy_q & (bitRateDivisor >= DIV_MIN) & (divCnt_q == bitRateDivisor - DIV_ONE);
      mstEdge    = mstTick & (edgeCnt_q < edgesTotal);
      mstEnd     = mstTick & (edgeCnt_q >= edgesTotal);
      // RL15: slave edges only counted outside master mode
      slvEdge    = slaveSel & (sckIn != sckPrev_q) & (edgeCnt_q < edgesTotal);
      anyEdge    = mstEdge | slvEdge;
      // RL23: odd edges sample with phase zero
      // RL24: even edges sample with phase one
      sampleEdge = anyEdge & (edgeCnt_q[0] == clockPhaseSel);
      driveEdge  = anyEdge & (edgeCnt_q[0] != clockPhaseSel);
      slvDone    = slvEdge & sampleEdge & (edgeCnt_q == lastSample);
      // RL10: completion in either mode
      xferEvt    = mstEnd | slvDone;
      busyAny    = mstBusy_q | (clockPhaseSel ? slvBusy_q : slaveSel);
      // RL5: write while busy collides
      collide    = dataWr & busyAny;
      // RL12: otherwise the write goes straight in
      loadOk     = dataWr & ~busyAny;
      // RL18: status read then data access
      clrSeq     = statusSeen_q & (dataRd | dataWr);
      doneKeep   = xferDoneFlag_q & ~clrSeq;
      inBit      = masterSelect ? misoIn : mosiIn;
   end

   // RL3: sample shifts in while outgoing bit stays latched
   always_comb begin
      shift_d = shift_q;
      if (lowBitFirst) begin
         if (wordSize16) begin
            shift_d = {inBit, shift_q[SHIFT_W-1:1]};
         end else begin
            shift_d = {shift_q[SHIFT_W-1:BYTE_W], inBit, shift_q[BYTE_W-1:1]};
         end
      end else begin
         shift_d = {shift_q[SHIFT_W-2:0], inBit};
      end
   end

   // ---------------------------------------------------------------
   // shifter and outgoing bit
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         shift_q <= DATA_RST;
      end else if (loadOk) begin
         // RL12: direct load, no transmit buffer
         shift_q <= wrData;
      end else if (sampleEdge) begin
         shift_q <= shift_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         outBit_q <= LEVEL_RST;
      end else if (loadOk) begin
         outBit_q <= firstBit(wrData, lowBitFirst, wordSize16);
      end else if (driveEdge) begin
         // RL19: drive edge set by phase
         outBit_q <= firstBit(shift_q, lowBitFirst, wordSize16);
      end
   end

   // ---------------------------------------------------------------
   // master bit-rate generator and sequencing
   // ---------------------------------------------------------------
   // RL2: half period is divisor clocks
   // RL21: counter only runs for a master transfer
   always_ff @(posedge clk) begin
      if (rst) begin
         divCnt_q <= DIV_RST;
      end else if (~mstBusy_q | mstTick) begin
         divCnt_q <= DIV_RST;
      end else begin
         divCnt_q <= divCnt_q + DIV_ONE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mstBusy_q <= FLAG_RST;
      end else if (faultNow | ~portEnable | ~masterSelect | mstEnd) begin
         mstBusy_q <= FLAG_RST;
      end else if (loadOk & isMaster) begin
         // RL9: write starts master transfer
         mstBusy_q <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         slvBusy_q <= FLAG_RST;
      end else if (~slaveSel | slvDone) begin
         slvBusy_q <= FLAG_RST;
      end else if (slvEdge) begin
         slvBusy_q <= 1'b1;
      end
   end

   // phase-one slaves may keep select low, so the count restarts at completion
   always_ff @(posedge clk) begin
      if (rst) begin
         edgeCnt_q <= EDGE_RST;
      end else if (loadOk | xferEvt | (~masterSelect & ~slaveSel) | (masterSelect & ~mstBusy_q)) begin
         edgeCnt_q <= EDGE_RST;
      end else if (anyEdge) begin
         edgeCnt_q <= edgeCnt_q + 6'h01;
      end
   end

   // the edge detector follows the pin through reset, so no false edge follows it
   always_ff @(posedge clk) begin
      sckPrev_q <= sckIn;
      if (rst) begin
         sckLevel_q <= LEVEL_RST;
      end else if (~mstBusy_q) begin
         // RL27: idle at polarity level
         sckLevel_q <= clockPolaritySel;
      end else if (mstEdge) begin
         sckLevel_q <= ~sckLevel_q;
      end
   end

   // ---------------------------------------------------------------
   // status flags and read buffer
   // ---------------------------------------------------------------
   // RL8: flags set only by events here
   always_ff @(posedge clk) begin
      if (rst) begin
         xferDoneFlag_q <= FLAG_RST;
         overrunFlag_q  <= FLAG_RST;
         rdData_q       <= DATA_RST;
      end else begin
         // RL11: uncleared flag makes the new word overrun
         if (xferEvt & ~doneKeep) begin
            rdData_q <= wordSize16 ? (slvDone ? shift_d : shift_q)
                                   : {8'h00, (slvDone ? shift_d[BYTE_W-1:0] : shift_q[BYTE_W-1:0])};
         end
         xferDoneFlag_q <= xferEvt | doneKeep;
         overrunFlag_q  <= (xferEvt & doneKeep) | (overrunFlag_q & ~clrSeq);
      end
   end

   // RL26: collision flag only, transfer untouched
   always_ff @(posedge clk) begin
      if (rst) begin
         writeCollisionFlag_q <= FLAG_RST;
         modeFaultFlag_q      <= FLAG_RST;
      end else begin
         writeCollisionFlag_q <= collide | (writeCollisionFlag_q & ~clrSeq);
         modeFaultFlag_q      <= faultNow | (modeFaultFlag_q & ~clrSeq);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         statusSeen_q <= FLAG_RST;
      end else if (clrSeq) begin
         statusSeen_q <= FLAG_RST;
      end else if (statusRd & (xferDoneFlag_q | writeCollisionFlag_q | overrunFlag_q | modeFaultFlag_q)) begin
         statusSeen_q <= 1'b1;
      end
   end

   // RL17: request tracks flag when enabled
   always_ff @(posedge clk) begin
      if (rst) begin
         irqReq_q <= FLAG_RST;
      end else begin
         irqReq_q <= xferIrqEnable & (xferEvt | doneKeep);
      end
   end

   // ---------------------------------------------------------------
   // pin drivers
   // ---------------------------------------------------------------
   // RL6: fault removes master drivers
   // RL4: slave drives only while selected
   // RL13: open drain drives low only
   always_ff @(posedge clk) begin
      if (rst) begin
         sckOut_q  <= LEVEL_RST;
         sckOe_q   <= FLAG_RST;
         mosiOut_q <= LEVEL_RST;
         mosiOe_q  <= FLAG_RST;
         misoOut_q <= LEVEL_RST;
         misoOe_q  <= FLAG_RST;
      end else begin
         sckOut_q  <= openDrainSelect ? 1'b0 : sckLevel_q;
         sckOe_q   <= isMaster & ~faultNow & (~openDrainSelect | ~sckLevel_q);
         mosiOut_q <= openDrainSelect ? 1'b0 : outBit_q;
         mosiOe_q  <= isMaster & ~faultNow & (~openDrainSelect | ~outBit_q);
         misoOut_q <= openDrainSelect ? 1'b0 : outBit_q;
         misoOe_q  <= slaveSel & (~openDrainSelect | ~outBit_q);
      end
   end

endmodule

`default_nettype wire

// >>> design/ssp_pkg.sv
// constants shared by the synchronous serial port
// assumes one 200 MHz system clock and synchronous active-high reset
package ssp_pkg;

   // ---------------------------------------------------------------
   // clock
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;

   // ---------------------------------------------------------------
   // word and counter widths
   // ---------------------------------------------------------------
   localparam int SHIFT_W = 16;
   localparam int BYTE_W  = 8;
   localparam int DIV_W   = 8;
   localparam int EDGE_W  = 6;

   // ---------------------------------------------------------------
   // serial clock edges per transfer and divisor limits
   // ---------------------------------------------------------------
   localparam logic [EDGE_W-1:0] EDGES_BYTE = 6'h10;
   localparam logic [EDGE_W-1:0] EDGES_WORD = 6'h20;
   localparam logic [EDGE_W-1:0] EDGE_LAST_OFS = 6'h02;
   localparam logic [DIV_W-1:0]  DIV_MIN    = 8'h02;
   localparam logic [DIV_W-1:0]  DIV_ONE    = 8'h01;

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [SHIFT_W-1:0] DATA_RST  = 16'h0000;
   localparam logic [DIV_W-1:0]   DIV_RST   = 8'h00;
   localparam logic [EDGE_W-1:0]  EDGE_RST  = 6'h00;
   localparam logic               FLAG_RST  = 1'b0;
   localparam logic               LEVEL_RST = 1'b0;

endpackage

// >>> tb/ssp_peer.sv
// far-side serial peripheral: a 16-bit full duplex shifter
// assumes sck and mosi are the resolved pin levels, seen on clk
`timescale 1ns/100ps
`default_nettype none
module ssp_peer (
   input  wire logic        clk,
   input  wire logic        sel,
   input  wire logic        clock_polarity_sel,
   input  wire logic        clock_phase_sel,
   input  wire logic        sck,
   input  wire logic        mosi,
   input  wire logic        load,
   input  wire logic [15:0] txIn,
   output logic             miso,
   output logic      [15:0] rx
);
   logic [15:0] tx;
   logic        sckPrev;
   logic        sampled;
   logic        junk = 1'b0;
   // never drives sck, the port stays the only master
   // a released line toggles, so a stale bit never passes for data
   assign miso = sel ? tx[15] : junk;
   always @(posedge clk) begin
      sckPrev <= sck;
      junk    <= ~junk;
      if (load) begin
         tx      <= txIn;
         sampled <= 1'b0;
      end else if (sel && sck !== sckPrev) begin
         // sample on one edge kind, shift on the other
         if (sck ^ clock_polarity_sel ^ clock_phase_sel) begin
            rx      <= {rx[14:0], mosi};
            sampled <= 1'b1;
         end else if (sampled) begin
            tx <= tx << 1;
         end
      end
   end
endmodule
`default_nettype wire

// >>> tb/ssp_port_monitor.sv
// assertions on the serial port pins and flags
// assumes it is bound into ssp_port with one clock and reset rst
`timescale 1ns/100ps
`default_nettype none
module ssp_port_monitor (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        portEnable,
   input wire logic        masterSelect,
   input wire logic        clockPhaseSel,
   input wire logic        clockPolaritySel,
   input wire logic        lowBitFirst,
   input wire logic        wordSize16,
   input wire logic        openDrainSelect,
   input wire logic        xferIrqEnable,
   input wire logic [7:0]  bitRateDivisor,
   input wire logic        statusRd,
   input wire logic        dataRd,
   input wire logic        dataWr,
   input wire logic [15:0] wrData,
   input wire logic [15:0] rdData_q,
   input wire logic        xferDoneFlag_q,
   input wire logic        writeCollisionFlag_q,
   input wire logic        overrunFlag_q,
   input wire logic        modeFaultFlag_q,
   input wire logic        irqReq_q,
   input wire logic        sckIn,
   input wire logic        sckOut_q,
   input wire logic        sckOe_q,
   input wire logic        mosiIn,
   input wire logic        mosiOut_q,
   input wire logic        mosiOe_q,
   input wire logic        misoIn,
   input wire logic        misoOut_q,
   input wire logic        misoOe_q,
   input wire logic        ssN
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ------------------------------
   // pin and flag relations
   // ------------------------------
   property p_idle; $rose(xferDoneFlag_q) && masterSelect && !openDrainSelect |-> sckOut_q == clockPolaritySel;
   endproperty
   a_idle: assert property (p_idle) else $error("sck off idle at done");
   property p_quiet; (ssN && !masterSelect)[*2] |-> !misoOe_q; endproperty
   a_quiet: assert property (p_quiet) else $error("unselected slave drives");
   property p_off; modeFaultFlag_q[*2] |-> !sckOe_q && !mosiOe_q; endproperty
   a_off: assert property (p_off) else $error("drivers on after fault");
   property p_fault; portEnable && masterSelect && !ssN |-> ##[1:2] modeFaultFlag_q; endproperty
   a_fault: assert property (p_fault) else $error("mode fault missed");
   property p_irq; $rose(xferDoneFlag_q) && xferIrqEnable |-> ##[0:1] irqReq_q; endproperty
   a_irq: assert property (p_irq) else $error("no interrupt on done");
   property p_write_collision_flag; $rose(writeCollisionFlag_q) |-> $past(dataWr); endproperty
   a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision without write");
   property p_od; openDrainSelect[*2] |-> !sckOut_q && !mosiOut_q && !misoOut_q; endproperty
   a_od: assert property (p_od) else $error("open drain drives high");
   property p_ovr; $rose(overrunFlag_q) |-> $stable(rdData_q); endproperty
   a_ovr: assert property (p_ovr) else $error("overrun word stored");
   c_done: cover property ($rose(xferDoneFlag_q));
   c_fault: cover property ($rose(modeFaultFlag_q));
   c_ovr: cover property ($rose(overrunFlag_q));
endmodule
bind ssp_port ssp_port_monitor i_mon (.*);
`default_nettype wire

// >>> tb/testbench.sv
// bench: software strobes plus far-side traffic on the serial pins
// assumes the peer model and the bound monitor are compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import ssp_pkg::*;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        portEnable, masterSelect, clockPhaseSel, clockPolaritySel, lowBitFirst;
   logic        wordSize16, openDrainSelect, xferIrqEnable, statusRd, dataRd, dataWr;
   logic        ssN, tbSck, tbMosi, peerSel, load, peerMiso;
   logic        xferDoneFlag_q, writeCollisionFlag_q, overrunFlag_q, modeFaultFlag_q, irqReq_q;
   logic        sckOut_q, sckOe_q, mosiOut_q, mosiOe_q, misoOut_q, misoOe_q;
   logic [7:0]  bitRateDivisor;
   logic [15:0] wrData, rdData_q, ptx, prx, d, t, e;
   int          n_errors = 0;
   int          check_count = 0;
   int          k;
   // undriven sck and mosi rest on their pull-ups, tbSck/tbMosi default high
   wire         sckIn = sckOe_q ? sckOut_q : tbSck;
   wire         mosiIn = mosiOe_q ? mosiOut_q : tbMosi;
   wire         misoIn = misoOe_q ? misoOut_q : peerMiso;
   ssp_port i_dut (.*);
   ssp_peer i_peer (.clk, .sel(peerSel), .clock_polarity_sel(clockPolaritySel), .clock_phase_sel(clockPhaseSel), .sck(sckIn),
                    .mosi(mosiIn), .load, .txIn(ptx), .miso(peerMiso), .rx(prx));
   initial forever #2.5 clk = ~clk;
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] x, input logic [15:0] y);
      check_count++;
      if (y !== x) begin
         n_errors++;
         $display("[ERR] %0t expected %h got %h", $time, x, y);
      end
   endtask
   task automatic wr(input logic [15:0] v);
      wrData = v;
      dataWr = 1'b1;
      cyc(1);
      dataWr = 1'b0;
   endtask
   task automatic clr();
      statusRd = 1'b1;
      cyc(1);
      statusRd = 1'b0;
      dataRd = 1'b1;
      cyc(1);
      dataRd = 1'b0;
      cyc(1);
   endtask
   task automatic ld(input logic [15:0] v);
      ptx = v;
      load = 1'b1;
      peerSel = 1'b1;
      cyc(1);
      load = 1'b0;
   endtask
   task automatic waitDone();
      for (k = 0; k < 300 && xferDoneFlag_q !== 1'b1; k++) cyc(1);
      chk(16'h0001, {15'h0000, xferDoneFlag_q});
      cyc(1);
   endtask
   function automatic logic [15:0] rev(input logic [15:0] v);
      for (int i = 0; i < 16; i++) rev[i] = v[15-i];
   endfunction
   task automatic print_verdict();
      if (n_errors == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // ------------------------------
   // tests
   // ------------------------------
   initial begin
      {portEnable, masterSelect, clockPhaseSel, clockPolaritySel, lowBitFirst, wordSize16} = 6'h00;
      {openDrainSelect, xferIrqEnable, statusRd, dataRd, dataWr, peerSel, load} = 7'h00;
      {ssN, tbSck, tbMosi} = 3'h7;
      {bitRateDivisor, wrData, ptx} = 40'h04_0000_0000;
      cyc(5);
      rst = 1'b0;
      chk(16'h0000, {misoOe_q, sckOe_q, mosiOe_q, xferDoneFlag_q, irqReq_q});
      portEnable = 1'b1;
      masterSelect = 1'b1;
      for (int m = 0; m < 6; m++) begin
         {clockPolaritySel, clockPhaseSel} = m[1:0];
         {lowBitFirst, wordSize16, openDrainSelect, xferIrqEnable} = {m == 4, m > 3, m == 5, m[0]};
         d = 16'h3c5a ^ m[15:0];
         t = 16'hc3a6 + m[15:0];
         cyc(3);
         ld(t);
         wr(d);
         waitDone();
         e = lowBitFirst ? rev(t) : wordSize16 ? t : {8'h00, t[15:8]};
         chk(e, rdData_q);
         e = lowBitFirst ? rev(d) : d;
         chk(wordSize16 ? e : {8'h00, e[7:0]}, wordSize16 ? prx : {8'h00, prx[7:0]});
         chk(m[0], irqReq_q);
         chk(clockPolaritySel, sckIn);
         clr();
         chk(16'h0000, {xferDoneFlag_q, irqReq_q});
      end
      {clockPolaritySel, clockPhaseSel, lowBitFirst, wordSize16, openDrainSelect} = 5'h00;
      cyc(3);
      ld(16'h9600);
      wr(16'h00c3);
      cyc(6);
      wr(16'h00ff);
      cyc(1);
      chk(1'b1, writeCollisionFlag_q);
      chk(1'b0, irqReq_q);
      waitDone();
      chk(8'hc3, prx[7:0]);
      xferIrqEnable = 1'b0;
      cyc(1);
      chk(1'b0, irqReq_q);
      ld(16'h1100);
      wr(16'h0055);
      for (k = 0; k < 300 && overrunFlag_q !== 1'b1; k++) cyc(1);
      chk(1'b1, overrunFlag_q);
      chk(8'h96, rdData_q);
      clr();
      chk(16'h0000, {writeCollisionFlag_q, overrunFlag_q, xferDoneFlag_q});
      clockPolaritySel = 1'b1;
      bitRateDivisor = 8'h01;
      cyc(3);
      wr(16'h00aa);
      cyc(60);
      chk(1'b0, xferDoneFlag_q);
      chk(1'b1, sckIn);
      portEnable = 1'b0;
      cyc(2);
      {portEnable, bitRateDivisor, ssN} = {1'b1, 8'h04, 1'b0};
      cyc(3);
      chk(1'b1, modeFaultFlag_q);
      chk(16'h0000, {sckOe_q, mosiOe_q});
      ssN = 1'b1;
      clr();
      chk(1'b0, modeFaultFlag_q);
      {masterSelect, bitRateDivisor} = 9'h000;
      // phase zero frames each word with select, phase one keeps select low
      for (int p = 0; p < 2; p++) begin
         {clockPhaseSel, clockPolaritySel, tbSck} = {3{p[0]}};
         cyc(2);
         chk(1'b0, misoOe_q);
         d = p[0] ? 16'h0036 : 16'h00a7;
         e = p[0] ? 16'h00c9 : 16'h005e;
         wr(d);
         ssN = 1'b0;
         cyc(2);
         for (int i = 7; i >= 0; i--) begin
            tbMosi = e[i];
            cyc(4);
            if (p == 0) begin
               t[i] = misoIn;
            end
            tbSck = ~p[0];
            cyc(3);
            if (p == 1) begin
               t[i] = misoIn;
            end
            tbSck = p[0];
            cyc(3);
         end
         cyc(3);
         chk(1'b1, xferDoneFlag_q);
         chk(e, rdData_q);
         chk(d[7:0], t[7:0]);
         if (p == 0) begin
            ssN = 1'b1;
            clr();
         end
      end
      ssN = 1'b1;
      print_verdict();
   end
   // the tests take about a thousand cycles; this span means a hang
   initial begin
      #100us;
      n_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
